/* core/port_c_mux_regs.vh */
/*
  Constants for the port C alternate-function mux: pin bit positions,
  reset values and the JTAG shift-out state codes.
  Assumes it is included by bare name from the core design files.
*/
`ifndef PORT_C_MUX_REGS_VH
`define PORT_C_MUX_REGS_VH

`define PC_BIT_OSC_OUT 3'h7
`define PC_BIT_OSC_IN 3'h6
`define PC_BIT_TDI 3'h5
`define PC_BIT_TDO 3'h4
`define PC_BIT_TMS 3'h3
`define PC_BIT_TCK 3'h2
`define PC_BIT_SDA 3'h1
`define PC_BIT_SCL 3'h0

`define PC_WIDTH 8
`define PC_RST_BYTE 8'h00
`define PC_JTAG_PULL_MASK 8'h2c
`define PC_JTAG_MASK 8'h3c
`define PC_OSC_MASK 8'hc0
`define PC_TWI_MASK 8'h03
`define PC_LINE_IDLE 1'b1

// TAP controller state codes in which data is shifted out
`define TAP_SHIFT_DR 4'h2
`define TAP_SHIFT_IR 4'ha

`endif

/* core/pin_override.v */
/*
  One port pin's override slice: picks between port control and an
  alternate function for output value, output enable and pull-up.
  Assumes all inputs are synchronous to clock_in.
*/
`include "port_c_mux_regs.vh"

module pin_override
(
  input wire override_in,
  input wire port_value_in,
  input wire port_dir_in,
  input wire port_pull_in,
  input wire pin_in,
  input wire alt_value_in,
  input wire alt_oe_in,
  input wire alt_pull_in,
  output wire value_out,
  output wire oe_out,
  output wire pull_out
);

  // Pull-up only applies to an undriven pin
  assign value_out = override_in ? alt_value_in : port_value_in;
  assign oe_out = override_in ? alt_oe_in : port_dir_in;
  assign pull_out = override_in ? alt_pull_in : (port_pull_in & ~port_dir_in & ~pin_in);

endmodule // pin_override

/* core/port_c_alternate_function_mux.v */
/*
  Port C alternate-function mux: timer crystal oscillator on bits 7..6,
  JTAG port on bits 5..2, two-wire bus on bits 1..0.
  Assumes the oscillator, TAP controller and two-wire unit sit outside
  and hand in their drive levels; pad resolves level from enables.
*/
// Contract
// - JTAG enabled keeps pull-ups on TDI, TMS, TCK, even during reset.
// - Bit 7 offers oscillator output pin, bit 6 oscillator input pin.
// - Bits 5,4,3,2 offer JTAG TDI, TDO, TMS, TCK.
// - Bit 1 offers two-wire data, bit 0 two-wire clock.
// - Clock select set detaches bit 7, drives oscillator amplifier output.
// - Clock select set detaches bit 6 as oscillator amplifier input.
// - JTAG enabled withholds the four test pins from general I/O.
// - Test data out stays high impedance except in shift-out TAP states.
`include "port_c_mux_regs.vh"

module port_c_alternate_function_mux
#(
  parameter WIDTH = `PC_WIDTH
)
(
  input wire clock_in,
  input wire rst_in,
  input wire async_timer_clock_select_in,
  input wire jtag_enable_in,
  input wire twi_enable_in,
  input wire [WIDTH-1:0] port_data_in,
  input wire [WIDTH-1:0] port_dir_in,
  input wire [WIDTH-1:0] port_pull_in,
  input wire [WIDTH-1:0] pin_in,
  input wire osc_drive_in,
  input wire tdo_value_in,
  input wire [3:0] tap_state_in,
  input wire sda_drive_low_in,
  input wire scl_drive_low_in,
  output reg [WIDTH-1:0] pin_value_out,
  output reg [WIDTH-1:0] pin_oe_out,
  output reg [WIDTH-1:0] pin_pull_out,
  output reg [WIDTH-1:0] port_read_out,
  output reg osc_in_out,
  output reg tdi_out,
  output reg tms_out,
  output reg tck_out,
  output reg sda_in_out,
  output reg scl_in_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Only the two shift states may lift the test data output out of high impedance
  function is_shift_state;
    input [3:0] st;
    begin
      is_shift_state = (st == `TAP_SHIFT_DR) || (st == `TAP_SHIFT_IR);
    end
  endfunction

  // Pins that an enabled set of alternate functions takes from port control
  function [WIDTH-1:0] taken_mask;
    input osc_sel;
    input jtag_sel;
    input twi_sel;
    begin
      taken_mask = {WIDTH{1'b0}};
      if (osc_sel)
      begin
        taken_mask = taken_mask | `PC_OSC_MASK;
      end
      if (jtag_sel)
      begin
        taken_mask = taken_mask | `PC_JTAG_MASK;
      end
      if (twi_sel)
      begin
        taken_mask = taken_mask | `PC_TWI_MASK;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Override selection

  wire osc_on = async_timer_clock_select_in;
  wire jtag_on = jtag_enable_in;
  wire twi_on = twi_enable_in;
  wire tdo_drive = jtag_on & is_shift_state(tap_state_in);
  wire [WIDTH-1:0] override;
  wire [WIDTH-1:0] value_next;
  wire [WIDTH-1:0] oe_next;
  wire [WIDTH-1:0] pull_next;
  reg [WIDTH-1:0] alt_value;
  reg [WIDTH-1:0] alt_oe;
  reg [WIDTH-1:0] alt_pull;

  assign override = taken_mask(osc_on, jtag_on, twi_on);

  // Alternate drive for every pin; only the bits that override selects matter
  always @*
  begin
    alt_value = {WIDTH{1'b0}};
    alt_oe = {WIDTH{1'b0}};
    alt_pull = {WIDTH{1'b0}};
    // Oscillator pair: bit 7 carries the amplifier output, bit 6 only listens
    alt_value[`PC_BIT_OSC_OUT] = osc_drive_in;
    alt_oe[`PC_BIT_OSC_OUT] = osc_on;
    alt_oe[`PC_BIT_OSC_IN] = 1'b0;
    // Crystal pins stay free of pull-ups to keep the oscillator margin
    alt_pull[`PC_BIT_OSC_OUT] = 1'b0;
    alt_pull[`PC_BIT_OSC_IN] = 1'b0;
    // Test port: only the data output is ever driven
    alt_value[`PC_BIT_TDO] = tdo_value_in;
    alt_oe[`PC_BIT_TDO] = tdo_drive;
    alt_oe[`PC_BIT_TDI] = 1'b0;
    alt_oe[`PC_BIT_TMS] = 1'b0;
    alt_oe[`PC_BIT_TCK] = 1'b0;
    // An unplugged probe leaves the test inputs floating; pull-ups hold them idle
    alt_pull[`PC_BIT_TDI] = 1'b1;
    alt_pull[`PC_BIT_TMS] = 1'b1;
    alt_pull[`PC_BIT_TCK] = 1'b1;
    // Two-wire lines are open drain: value stays zero, enable pulls low
    alt_value[`PC_BIT_SDA] = 1'b0;
    alt_value[`PC_BIT_SCL] = 1'b0;
    alt_oe[`PC_BIT_SDA] = sda_drive_low_in;
    alt_oe[`PC_BIT_SCL] = scl_drive_low_in;
    // Bus devices bring their own pull-ups
    alt_pull[`PC_BIT_SDA] = 1'b0;
    alt_pull[`PC_BIT_SCL] = 1'b0;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      pin_override u_pin
      (
        .override_in(override[i]),
        .port_value_in(port_data_in[i]),
        .port_dir_in(port_dir_in[i]),
        .port_pull_in(port_pull_in[i]),
        .pin_in(pin_in[i]),
        .alt_value_in(alt_value[i]),
        .alt_oe_in(alt_oe[i]),
        .alt_pull_in(alt_pull[i]),
        .value_out(value_next[i]),
        .oe_out(oe_next[i]),
        .pull_out(pull_next[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Function input routing

  // Taken oscillator and test pins read as zero so port software cannot see
  // alternate traffic; two-wire pins stay readable for bus monitoring
  wire [WIDTH-1:0] read_mask = taken_mask(osc_on, jtag_on, 1'b0);
  wire [WIDTH-1:0] read_next = pin_in & ~read_mask;
  wire osc_in_next = osc_on & pin_in[`PC_BIT_OSC_IN];
  wire tdi_next = jtag_on & pin_in[`PC_BIT_TDI];
  wire tms_next = jtag_on & pin_in[`PC_BIT_TMS];
  wire tck_next = jtag_on & pin_in[`PC_BIT_TCK];
  wire sda_next = pin_in[`PC_BIT_SDA];
  wire scl_next = pin_in[`PC_BIT_SCL];
  // Test port survives reset, so its pull-ups do too
  wire [WIDTH-1:0] reset_pull = jtag_on ? `PC_JTAG_PULL_MASK : `PC_RST_BYTE;

  ////////////////////////////////////////////////////////////////////////
  // Pad drive registers

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pin_value_out <= `PC_RST_BYTE;
      pin_oe_out <= `PC_RST_BYTE;
      pin_pull_out <= reset_pull;
    end
    else
    begin
      pin_value_out <= value_next;
      pin_oe_out <= oe_next;
      pin_pull_out <= pull_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port read register

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      port_read_out <= `PC_RST_BYTE;
    end
    else
    begin
      port_read_out <= read_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Function input registers

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      osc_in_out <= 1'b0;
      tdi_out <= 1'b0;
      tms_out <= 1'b0;
      tck_out <= 1'b0;
      // Released two-wire lines idle high
      sda_in_out <= `PC_LINE_IDLE;
      scl_in_out <= `PC_LINE_IDLE;
    end
    else
    begin
      osc_in_out <= osc_in_next;
      tdi_out <= tdi_next;
      tms_out <= tms_next;
      tck_out <= tck_next;
      sda_in_out <= sda_next;
      scl_in_out <= scl_next;
    end
  end

endmodule // port_c_alternate_function_mux

/* testbench/port_c_mux_chk.sv */
/* Port C mux checker: one-cycle relations of outputs to inputs.
   Assumes it is bound to the mux top and sees only its ports. */
module port_c_mux_chk
(
  input wire clock_in,
  input wire rst_in,
  input wire async_timer_clock_select_in,
  input wire jtag_enable_in,
  input wire twi_enable_in,
  input wire [7:0] port_data_in,
  input wire [7:0] port_dir_in,
  input wire osc_drive_in,
  input wire tdo_value_in,
  input wire [3:0] tap_state_in,
  input wire sda_drive_low_in,
  input wire scl_drive_low_in,
  input wire [7:0] pin_value_out,
  input wire [7:0] pin_oe_out,
  input wire [7:0] pin_pull_out,
  input wire [7:0] port_read_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // The first edge out of reset still shows reset values
  sequence s_up; !$past(rst_in); endsequence
  sequence s_osc; s_up ##0 $past(async_timer_clock_select_in); endsequence
  sequence s_jt; s_up ##0 $past(jtag_enable_in); endsequence
  property p_osc; s_osc |-> pin_oe_out[7:6] == 2'b10 && pin_value_out[7] == $past(osc_drive_in);
  endproperty
  a_osc: assert property (p_osc) else $error("osc pins");
  property p_oscin; s_osc |-> {port_read_out[7:6], pin_pull_out[7:6]} == 4'h0; endproperty
  a_oscin: assert property (p_oscin) else $error("osc input");
  property p_pull; s_jt |-> (pin_pull_out & 8'h2c) == 8'h2c; endproperty
  a_pull: assert property (p_pull) else $error("jtag pulls");
  property p_jin; s_jt |-> {pin_oe_out[5], pin_oe_out[3:2], port_read_out[5:2]} == 7'h0;
  endproperty
  a_jin: assert property (p_jin) else $error("jtag pins");
  property p_tdo; s_jt |-> pin_oe_out[4] == ($past(tap_state_in) inside {4'h2, 4'ha}); endproperty
  a_tdo: assert property (p_tdo) else $error("tdo enable");
  property p_tdv; s_jt ##0 pin_oe_out[4] |-> pin_value_out[4] == $past(tdo_value_in); endproperty
  a_tdv: assert property (p_tdv) else $error("tdo value");
  property p_twi; s_up ##0 $past(twi_enable_in) |-> pin_value_out[1:0] == 2'b00
    && pin_oe_out[1:0] == {$past(sda_drive_low_in), $past(scl_drive_low_in)}; endproperty
  a_twi: assert property (p_twi) else $error("twi pins");
  property p_io; s_up ##0 (!$past(async_timer_clock_select_in) && !$past(jtag_enable_in)
    && !$past(twi_enable_in)) |-> pin_oe_out == $past(port_dir_in)
    && (pin_value_out & pin_oe_out) == ($past(port_data_in) & $past(port_dir_in));
  endproperty
  a_io: assert property (p_io) else $error("port pins");
endmodule // port_c_mux_chk

/* testbench/port_c_pad_model.sv */
/* Pad model for port C: drive, else pull-up, else a level that flips.
   Assumes one clock; the pad settles one cycle after its drive. */
module port_c_pad_model
(
  input wire clock_in,
  input wire [7:0] value_in,
  input wire [7:0] oe_in,
  input wire [7:0] pull_in,
  output logic [7:0] pad_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pad_out = 8'h00;
  // A floating pad flips so no stale level passes for a real one
  // Two-wire lines carry the bus's own pull-ups on bits 1 and 0
  always @(posedge clock_in)
    pad_out <= (oe_in & value_in) | (~oe_in & (pull_in | 8'h03 | ~pad_out));
endmodule // port_c_pad_model

/* testbench/testbench.sv */
/* Random self-checking bench for the port C mux with two resets.
   Assumes the pad model feeds pin_in. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, rst_in = 1, async_timer_clock_select_in = 0, jtag_enable_in = 1;
  logic twi_enable_in = 0, osc_drive_in = 0, tdo_value_in = 0, sda_drive_low_in = 0;
  logic scl_drive_low_in = 0;
  logic [3:0] tap_state_in = 4'h0;
  logic [7:0] port_data_in = 8'h00, port_dir_in = 8'h00, port_pull_in = 8'h00;
  wire [7:0] pin_in, pin_value_out, pin_oe_out, pin_pull_out, port_read_out;
  wire osc_in_out, tdi_out, tms_out, tck_out, sda_in_out, scl_in_out;
  logic [31:0] r = 32'hd403;
  logic [31:0] w;
  logic [37:0] e;
  wire [5:0] fn_in = {osc_in_out, tdi_out, tms_out, tck_out, sda_in_out, scl_in_out};
  int err_count = 0, num_checks = 0;
  port_c_alternate_function_mux u_dut (.*);
  port_c_pad_model u_pad (.clock_in(clock_in), .value_in(pin_value_out), .oe_in(pin_oe_out),
    .pull_in(pin_pull_out), .pad_out(pin_in));
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected registered outputs for one set of sampled inputs
  function automatic [37:0] f(input a, j, t, od, tv, sd, sc, input [3:0] st,
    input [7:0] dat, dir, pu, pin);
    logic [7:0] val, oe, pl, rd;
    val = dat;
    oe = dir;
    pl = pu & ~dir & ~pin;
    rd = pin;
    if (a)
      {val[7:6], oe[7:6], pl[7:6], rd[7:6]} = {od, 1'b0, 6'h20};
    if (j)
      {val[5:2], oe[5:2], pl[5:2], rd[5:2]} = {1'b0, tv, 2'b00, 1'b0,
        st == 4'h2 || st == 4'ha, 2'b00, 8'hb0};
    if (t)
      {val[1:0], oe[1:0], pl[1:0]} = {2'b00, sd, sc, 2'b00};
    return {val, oe, pl, rd, a & pin[6], j & pin[5], j & pin[3], j & pin[2], pin[1:0]};
  endfunction
  task automatic check(input [37:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic jt);
    rst_in <= 1'b1;
    jtag_enable_in <= jt;
    repeat (11) @(posedge clock_in);
    #1;
    check({pin_value_out, pin_oe_out, port_read_out}, 24'h0);
    check(pin_pull_out, jt ? 8'h2c : 8'h00);
    check(fn_in, 6'h03);
    @(posedge clock_in);
    rst_in <= 1'b0;
  endtask
  initial forever #50 clock_in = ~clock_in;
  initial
  begin
    do_reset(1'b1);
    for (int i = 0; i < 400; i++)
    begin
      if (i == 200)
        do_reset(1'b0);
      @(posedge clock_in);
      e = f(async_timer_clock_select_in, jtag_enable_in, twi_enable_in, osc_drive_in,
        tdo_value_in, sda_drive_low_in, scl_drive_low_in, tap_state_in, port_data_in,
        port_dir_in, port_pull_in, pin_in);
      r = xs(r);
      // Hand-picked corners on the second to fifth words after each reset, random words otherwise
      case (i % 200)
        1: w = 32'hffffff2f;
        2: w = 32'ha5ff00a0;
        3: w = 32'h0000ffa4;
        4: w = 32'hf00f3c0a;
        default: w = r;
      endcase
      {port_data_in, port_dir_in, port_pull_in, tap_state_in, async_timer_clock_select_in,
        jtag_enable_in, twi_enable_in, osc_drive_in} <= w;
      r = xs(r);
      {tdo_value_in, sda_drive_low_in, scl_drive_low_in} <= r[2:0];
      #1;
      check(pin_value_out, e[37:30]);
      check(pin_oe_out, e[29:22]);
      check(pin_pull_out, e[21:14]);
      check(port_read_out, e[13:6]);
      check(fn_in, e[5:0]);
    end
    test_done;
  end
  initial
  begin
    #1000000;
    err_count++;
    test_done;
  end
endmodule // testbench
bind port_c_alternate_function_mux port_c_mux_chk u_chk (.*);
